// ==== rtl/hbd_pkg.sv ====
//==============================================================
// What this block does
// - Enable low: sleep, outputs off, banks reset.
// - Enable high: outputs follow command banks again.
// - Status clear acts only after frame ends.
// - Status clear wipes faults of selected group.
// - Persisting fault re-latches after status clear.
// - Enable toggle or power-on clears all faults.
// - Low-side under-load past delay sets open-load.
// - One shared timer; late channels qualify at expiry.
// - Shared timer runs while any under-load persists.
// - Open-load shutdown enable decides output switch-off.
// - Group select steers clear and shutdown enable.
// - Group two readback layout, reserved bits zero.
// - Readback reports active and high-side selection.
// - Thermal shutdown latches with output switch-off.
// - Over-current past delay latches flag, output off.
// - Warning follows comparator; shutdown latches both switches.
// - Thermal flag clears only when cool and cleared.
// - Drive supply undervoltage past delay: supply fail.
// - Logic supply low: silent port, all cleared.
// - Over-voltage lockout in either group, unlatched.
// - Unlatched faults recover to commanded state.
// - Command bit 14 selects channel group.
// - Command bit 15 requests status clear.
// - Command bit 13 enables open-load shutdown.
// - Command bit 0 enables over-voltage lockout.
//==============================================================
package hbd_pkg;

  // Channel counts: group one is channels 1..6, group two 7..10.
  localparam int NCH     = 10;
  localparam int G1_N    = 6;
  localparam int G2_N    = 4;
  localparam int FRAME_N = 16;

  // Command frame fields.
  localparam int CMD_SRR_BIT  = 15;
  localparam int CMD_GSEL_BIT = 14;
  localparam int CMD_OLSD_BIT = 13;
  localparam int CMD_EN_LSB   = 7;
  localparam int CMD_CFG_LSB  = 1;
  localparam int CMD_OVERVOLTAGE_LOCKOUT_ENABLE_BIT = 0;
  localparam logic [15:0] CMD_RESET = 16'h0000;

  // Diagnostic word fields; bit 16 is the pre-frame bit.
  localparam int DG_TSD_BIT = 16;
  localparam int DG_OC_BIT  = 15;
  localparam int DG_PSF_BIT = 14;
  localparam int DG_OL_BIT  = 13;
  localparam int DG_TW_BIT  = 0;

  // Timebase and qualification delays, counted in ticks.
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OL_DELAY_US   = 200;
  localparam int OC_DELAY_US   = 10;
  localparam int UV_DELAY_US   = 20;

  // Summary flags of one channel group.
  typedef struct packed {
    logic thermal_shutdown_flag;
    logic oc;
    logic supply_fail_flag;
    logic ol;
    logic tw;
  } hbd_diag_t;

  // Synchronised comparator levels.
  typedef struct packed {
    logic [NCH-1:0] ul;
    logic [NCH-1:0] oc;
    logic [NCH-1:0] tw;
    logic [NCH-1:0] thermal_shutdown_flag;
    logic           vs_uv;
    logic           vs_ov;
  } hbd_sense_t;

  typedef enum logic {SPI_IDLE, SPI_SHIFT} hbd_spi_st_t;

  // Channels belonging to the group picked by a select bit.
  function automatic logic [NCH-1:0] hbd_group_mask(input logic gsel);
    hbd_group_mask = gsel ? {{G2_N{1'b1}}, {G1_N{1'b0}}} : {{G2_N{1'b0}}, {G1_N{1'b1}}};
  endfunction

endpackage

// ==== rtl/hbd_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
//==============================================================
// Two-flop synchroniser for a bundle of slow levels.
//==============================================================
module hbd_sync #(
  parameter int                W       = 1,
  parameter logic [W-1:0]      RST_VAL = '0
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Levels.
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;  // First stage, read only by the second.

  // Both stages share the reset constant so idle levels hold.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= RST_VAL;
      q_o      <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/hbd_delay.sv ====
`timescale 1ns/1ps
`default_nettype none
//==============================================================
// Qualification delay: a condition must hold for LIMIT ticks.
//==============================================================
module hbd_delay #(
  parameter int LIMIT = 1
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control.
  input  wire logic clr_i,
  input  wire logic tick_i,
  input  wire logic cond_i,
  // Qualified level.
  output logic      hit_o
);

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  logic [CW-1:0] cnt_reg;  // Ticks seen while the condition holds.

  // A zero limit would qualify without any delay at all.
  if (LIMIT < 1) begin : g_bad_limit
    $error("hbd_delay LIMIT must be at least one tick");
  end

  // Any gap in the condition restarts the count from zero.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      hit_o   <= 1'b0;
    end else if (clr_i || !cond_i) begin
      cnt_reg <= '0;
      hit_o   <= 1'b0;
    end else begin
      if (tick_i && cnt_reg != LIM) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      hit_o <= (cnt_reg == LIM);
    end
  end

endmodule
`default_nettype wire

// ==== rtl/hbd_fault_diag.sv ====
`timescale 1ns/1ps
`default_nettype none
//==============================================================
// Half-bridge fault supervision with serial command/diagnostic port.
//==============================================================
module hbd_fault_diag #(
  parameter int OL_DELAY_TICKS = hbd_pkg::OL_DELAY_US,
  parameter int OC_DELAY_TICKS = hbd_pkg::OC_DELAY_US,
  parameter int UV_DELAY_TICKS = hbd_pkg::UV_DELAY_US
) (
  // Clock and reset.
  input  wire logic                     REF_CLK_I,
  input  wire logic                     SYS_RST_I,
  // Serial port pins.
  input  wire logic                     SCLK_I,
  input  wire logic                     CS_N_I,
  input  wire logic                     SERIAL_DATA_IN_I,
  output logic                          SDO_O,
  output logic                          SDO_OE_O,
  // Enable and logic-supply good pins.
  input  wire logic                     ENABLE_I,
  input  wire logic                     VCC_OK_I,
  // Comparator levels per channel, bit 0 is channel 1.
  input  wire logic [hbd_pkg::NCH-1:0]  UNDERLOAD_I,
  input  wire logic [hbd_pkg::NCH-1:0]  OVERCUR_I,
  input  wire logic [hbd_pkg::NCH-1:0]  TEMP_WARN_I,
  input  wire logic [hbd_pkg::NCH-1:0]  TEMP_SD_I,
  input  wire logic                     VS_UV_I,
  input  wire logic                     VS_OV_I,
  // Gate drive per channel.
  output logic [hbd_pkg::NCH-1:0]       HS_ON_O,
  output logic [hbd_pkg::NCH-1:0]       LS_ON_O
);
  import hbd_pkg::*;

  //==============================================================
  // Parameter checks
  //==============================================================
  if (OL_DELAY_TICKS < 1 || OC_DELAY_TICKS < 1 || UV_DELAY_TICKS < 1) begin : g_bad_delay
    $error("hbd_fault_diag delays must be at least one tick");
  end

  //==============================================================
  // Input synchronisation
  //==============================================================
  localparam int SYNC_W = 5 + 2 + 4 * NCH;
  // Chip select idles high so no false frame starts out of reset.
  localparam logic [SYNC_W-1:0] SYNC_RST = {1'b0, 1'b1, {(SYNC_W - 2){1'b0}}};

  logic [SYNC_W-1:0] sync_q;    // Synchronised pin bundle.
  logic              sclk_s;    // Serial clock level.
  logic              cs_n_s;    // Chip select level.
  logic              sdi_s;     // Serial data level.
  logic              en_s;      // Enable level.
  logic              vcc_ok_s;  // Logic supply good level.
  hbd_sense_t        sense;     // Comparator levels.

  hbd_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk_i (REF_CLK_I),
    .rst_i (SYS_RST_I),
    .d_i   ({SCLK_I, CS_N_I, SERIAL_DATA_IN_I, ENABLE_I, VCC_OK_I,
             UNDERLOAD_I, OVERCUR_I, TEMP_WARN_I, TEMP_SD_I, VS_UV_I, VS_OV_I}),
    .q_o   (sync_q)
  );

  assign sclk_s   = sync_q[SYNC_W-1];
  assign cs_n_s   = sync_q[SYNC_W-2];
  assign sdi_s    = sync_q[SYNC_W-3];
  assign en_s     = sync_q[SYNC_W-4];
  assign vcc_ok_s = sync_q[SYNC_W-5];
  assign sense    = sync_q[SYNC_W-6:0];

  // Sleep covers both the enable pin and logic-supply lockout.
  logic sleep;
  assign sleep = !en_s || !vcc_ok_s;

  //==============================================================
  // Timebase
  //==============================================================
  localparam int TW_W = $clog2(TICK_CYCLES);
  localparam logic [TW_W-1:0] TICK_LAST = TW_W'(TICK_CYCLES - 1);

  logic [TW_W-1:0] tick_cnt_reg;  // Divider for the delay tick.
  logic            tick_reg;      // One-cycle tick enable.

  // Free-running divider; delays are coarse so phase does not matter.
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg     <= (tick_cnt_reg == TICK_LAST);
      tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? '0 : tick_cnt_reg + 1'b1;
    end
  end

  //==============================================================
  // Serial frame engine
  //==============================================================
  hbd_spi_st_t        st_reg;        // Frame state.
  logic               sclk_d_reg;    // Previous serial clock level.
  logic               cs_n_d_reg;    // Previous chip select level.
  logic [FRAME_N-1:0] shin_reg;      // Received command bits.
  logic [4:0]         bits_reg;      // Bits received, saturating.
  logic [FRAME_N:0]   shout_reg;     // Diagnostic bits, pre-bit on top.
  logic               frame_done;    // Complete frame at deselect.
  logic [FRAME_N:0]   diag_g1;       // Group one readback.
  logic [FRAME_N:0]   diag_g2;       // Group two readback.
  logic               last_gsel_reg; // Group of the last command.

  assign frame_done = (st_reg == SPI_SHIFT) && cs_n_s && !cs_n_d_reg && (bits_reg == 5'h10);

  // Edge tracking reads only the second synchroniser stage.
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sclk_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  // Bits are taken on rising clock; the answer moves on too.
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st_reg    <= SPI_IDLE;
      shin_reg  <= '0;
      bits_reg  <= '0;
      shout_reg <= '0;
    end else if (sleep) begin
      st_reg    <= SPI_IDLE;
      shout_reg <= '0;
    end else begin
      case (st_reg)
        SPI_IDLE: begin
          if (!cs_n_s && cs_n_d_reg) begin
            // Snapshot at select: the pre-bit is visible before clock.
            st_reg    <= SPI_SHIFT;
            bits_reg  <= '0;
            shout_reg <= last_gsel_reg ? diag_g2 : diag_g1;
          end
        end
        SPI_SHIFT: begin
          if (cs_n_s) begin
            st_reg <= SPI_IDLE;
          end else if (sclk_s && !sclk_d_reg) begin
            shin_reg  <= {shin_reg[FRAME_N-2:0], sdi_s};
            shout_reg <= {shout_reg[FRAME_N-1:0], 1'b0};
            if (bits_reg != 5'h1f) begin
              bits_reg <= bits_reg + 1'b1;
            end
          end
        end
        default: st_reg <= SPI_IDLE;
      endcase
    end
  end

  // The data pin is driven only inside an active frame.
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      SDO_O    <= 1'b0;
      SDO_OE_O <= 1'b0;
    end else begin
      SDO_O    <= shout_reg[FRAME_N];
      SDO_OE_O <= (st_reg == SPI_SHIFT) && !cs_n_s && !sleep;
    end
  end

  //==============================================================
  // Command banks
  //==============================================================
  logic [15:0]    bank_g1_reg;   // Group one command.
  logic [15:0]    bank_g2_reg;   // Group two command.
  logic [NCH-1:0] clr_mask_reg;  // One-cycle status clear per channel.
  logic [NCH-1:0] cmd_en;        // Commanded active.
  logic [NCH-1:0] cmd_cfg;       // Commanded high side.
  logic [NCH-1:0] olsd_ch;       // Open-load shutdown per channel.
  logic           overvoltage_lockout_enable_en;       // Over-voltage lockout armed.

  // A frame is only acted on once the host deselects, never mid-shift.
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      bank_g1_reg   <= CMD_RESET;
      bank_g2_reg   <= CMD_RESET;
      last_gsel_reg <= 1'b0;
      clr_mask_reg  <= '0;
    end else if (sleep) begin
      bank_g1_reg   <= CMD_RESET;
      bank_g2_reg   <= CMD_RESET;
      last_gsel_reg <= 1'b0;
      clr_mask_reg  <= '0;
    end else begin
      clr_mask_reg <= '0;
      if (frame_done) begin
        last_gsel_reg <= shin_reg[CMD_GSEL_BIT];
        if (shin_reg[CMD_GSEL_BIT]) begin
          bank_g2_reg <= shin_reg;
        end else begin
          bank_g1_reg <= shin_reg;
        end
        if (shin_reg[CMD_SRR_BIT]) begin
          clr_mask_reg <= hbd_group_mask(shin_reg[CMD_GSEL_BIT]);
        end
      end
    end
  end

  assign cmd_en  = {bank_g2_reg[CMD_EN_LSB+:G2_N], bank_g1_reg[CMD_EN_LSB+:G1_N]};
  assign cmd_cfg = {bank_g2_reg[CMD_CFG_LSB+:G2_N], bank_g1_reg[CMD_CFG_LSB+:G1_N]};
  assign olsd_ch = ({NCH{bank_g2_reg[CMD_OLSD_BIT]}} & hbd_group_mask(1'b1))
                 | ({NCH{bank_g1_reg[CMD_OLSD_BIT]}} & hbd_group_mask(1'b0));
  assign overvoltage_lockout_enable_en = bank_g1_reg[CMD_OVERVOLTAGE_LOCKOUT_ENABLE_BIT] | bank_g2_reg[CMD_OVERVOLTAGE_LOCKOUT_ENABLE_BIT];

  //==============================================================
  // Qualification delays
  //==============================================================
  logic [NCH-1:0] oc_hit;  // Over-current held past its delay.
  logic           uv_hit;  // Drive supply low past its delay.

  for (genvar i = 0; i < NCH; i++) begin : g_oc
    hbd_delay #(
      .LIMIT (OC_DELAY_TICKS)
    ) u_oc (
      .clk_i  (REF_CLK_I),
      .rst_i  (SYS_RST_I),
      .clr_i  (sleep),
      .tick_i (tick_reg),
      .cond_i (sense.oc[i]),
      .hit_o  (oc_hit[i])
    );
  end

  hbd_delay #(
    .LIMIT (UV_DELAY_TICKS)
  ) u_uv (
    .clk_i  (REF_CLK_I),
    .rst_i  (SYS_RST_I),
    .clr_i  (sleep),
    .tick_i (tick_reg),
    .cond_i (sense.vs_uv),
    .hit_o  (uv_hit)
  );

  //==============================================================
  // Shared open-load timer
  //==============================================================
  localparam int OW = $clog2(OL_DELAY_TICKS + 1);
  localparam logic [OW-1:0] OL_LIM = OW'(OL_DELAY_TICKS);

  logic [OW-1:0]  ol_cnt_reg;  // Ticks since under-load began.
  logic           ol_expire;   // Timer reached its delay this cycle.
  logic [NCH-1:0] ul_act;      // Under-load on a conducting low side.

  // Only a low side that is actually on can see under-load current.
  assign ul_act    = sense.ul & LS_ON_O;
  assign ol_expire = tick_reg && (ol_cnt_reg == OL_LIM);

  // One timer for all: a late channel inherits the time left, and the
  // timer wraps and keeps going while any under-load persists.
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ol_cnt_reg <= '0;
    end else if (sleep || ul_act == '0) begin
      ol_cnt_reg <= '0;
    end else if (ol_expire) begin
      ol_cnt_reg <= OW'(1);
    end else if (tick_reg) begin
      ol_cnt_reg <= ol_cnt_reg + 1'b1;
    end
  end

  //==============================================================
  // Latched faults
  //==============================================================
  logic [NCH-1:0] tsd_reg;      // Thermal shutdown latched.
  logic [NCH-1:0] oc_reg;       // Over-current latched.
  logic [NCH-1:0] ol_reg;       // Open-load flag latched.
  logic [NCH-1:0] ol_off_reg;   // Open-load switch-off latched.
  logic [NCH-1:0] tsd_next;     // Next thermal state.
  logic [NCH-1:0] oc_next;      // Next over-current state.
  logic [NCH-1:0] ol_next;      // Next open-load flag.
  logic [NCH-1:0] ol_off_next;  // Next open-load switch-off.
  logic [NCH-1:0] ol_set;       // Open-load qualified now.
  logic           psf_reg;      // Supply fail, unlatched.
  logic           psf_next;     // Next supply fail.

  assign ol_set = ol_expire ? ul_act : '0;

  // Set beats clear so a fault still present re-latches at once;
  // thermal can only clear once the comparator has dropped.
  always_comb begin
    tsd_next    = (tsd_reg & ~clr_mask_reg) | sense.thermal_shutdown_flag;
    oc_next     = (oc_reg & ~clr_mask_reg) | oc_hit;
    ol_next     = (ol_reg & ~clr_mask_reg) | ol_set;
    ol_off_next = (ol_off_reg & ~clr_mask_reg) | (ol_set & olsd_ch);
    psf_next    = uv_hit || (sense.vs_ov && overvoltage_lockout_enable_en);
  end

  // Sleep wipes every latch, so an enable toggle acts as a full clear.
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      tsd_reg    <= '0;
      oc_reg     <= '0;
      ol_reg     <= '0;
      ol_off_reg <= '0;
      psf_reg    <= 1'b0;
    end else if (sleep) begin
      tsd_reg    <= '0;
      oc_reg     <= '0;
      ol_reg     <= '0;
      ol_off_reg <= '0;
      psf_reg    <= 1'b0;
    end else begin
      tsd_reg    <= tsd_next;
      oc_reg     <= oc_next;
      ol_reg     <= ol_next;
      ol_off_reg <= ol_off_next;
      psf_reg    <= psf_next;
    end
  end

  //==============================================================
  // Output stages
  //==============================================================
  logic [NCH-1:0] drive_on;  // Channel may conduct this cycle.

  // Faults gate from their next values so the switch-off lands on the
  // same edge as the flag; supply fail holds no memory of its own.
  assign drive_on = cmd_en & ~tsd_next & ~oc_next & ~ol_off_next
                  & {NCH{!psf_next && !sleep}};

  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      HS_ON_O <= '0;
      LS_ON_O <= '0;
    end else begin
      HS_ON_O <= drive_on & cmd_cfg;
      LS_ON_O <= drive_on & ~cmd_cfg;
    end
  end

  //==============================================================
  // Diagnostic readback
  //==============================================================
  hbd_diag_t      sum_g1;  // Group one summary.
  hbd_diag_t      sum_g2;  // Group two summary.
  logic [NCH-1:0] active;  // Half-bridge currently driven.

  assign active = HS_ON_O | LS_ON_O;

  // Build the two readback words; reserved bits stay zero.
  always_comb begin
    sum_g1.thermal_shutdown_flag = |tsd_reg[G1_N-1:0];
    sum_g1.oc  = |oc_reg[G1_N-1:0];
    sum_g1.supply_fail_flag = psf_reg;
    sum_g1.ol  = |ol_reg[G1_N-1:0];
    sum_g1.tw  = |sense.tw[G1_N-1:0];
    sum_g2.thermal_shutdown_flag = |tsd_reg[NCH-1:G1_N];
    sum_g2.oc  = |oc_reg[NCH-1:G1_N];
    sum_g2.supply_fail_flag = psf_reg;
    sum_g2.ol  = |ol_reg[NCH-1:G1_N];
    sum_g2.tw  = |sense.tw[NCH-1:G1_N];
    diag_g1 = '0;
    diag_g1[DG_TSD_BIT] = sum_g1.thermal_shutdown_flag;
    diag_g1[DG_OC_BIT]  = sum_g1.oc;
    diag_g1[DG_PSF_BIT] = sum_g1.supply_fail_flag;
    diag_g1[DG_OL_BIT]  = sum_g1.ol;
    diag_g1[CMD_EN_LSB+:G1_N]  = active[G1_N-1:0];
    diag_g1[CMD_CFG_LSB+:G1_N] = cmd_cfg[G1_N-1:0];
    diag_g1[DG_TW_BIT]  = sum_g1.tw;
    diag_g2 = '0;
    diag_g2[DG_TSD_BIT] = sum_g2.thermal_shutdown_flag;
    diag_g2[DG_OC_BIT]  = sum_g2.oc;
    diag_g2[DG_PSF_BIT] = sum_g2.supply_fail_flag;
    diag_g2[DG_OL_BIT]  = sum_g2.ol;
    diag_g2[CMD_EN_LSB+:G2_N]  = active[NCH-1:G1_N];
    diag_g2[CMD_CFG_LSB+:G2_N] = cmd_cfg[NCH-1:G1_N];
    diag_g2[DG_TW_BIT]  = sum_g2.tw;
  end

endmodule
`default_nettype wire

// ==== testbench/hbd_host.sv ====
`timescale 1ns/1ps
`default_nettype none
//==========
// Serial host model: sends frames and samples the readback word.
module hbd_host (
  // Clock and readback.
  input  wire logic clk_i,
  input  wire logic sdo_i,
  // Serial pins.
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      di_o
);
  // Serial clock stands low outside frames.
  initial begin
    sclk_o = 1'h0;
    cs_n_o = 1'h1;
    di_o   = 1'h0;
  end
  // Wait n edges, then step just past the edge.
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One frame, MSB first; rd collects the pre-bit, then bits 15..0.
  task automatic xfer(input logic [15:0] cmd, output logic [16:0] rd);
    w(1);
    cs_n_o = 1'h0;
    w(5);
    for (int i = 15; i >= 0; i--) begin
      di_o = cmd[i];
      w(4);
      rd = {rd[15:0], sdo_i};
      sclk_o = 1'h1;
      w(4);
      sclk_o = 1'h0;
    end
    w(4);
    rd = {rd[15:0], sdo_i};
    cs_n_o = 1'h1;
    // A released data line shows the inverse, so a stale bit cannot pass.
    di_o = ~di_o;
    w(8);
  endtask
endmodule
`default_nettype wire

// ==== testbench/hbd_fault_diag_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
//==========
// Pin checks of drive, sleep and readback enable.
module hbd_fault_diag_chk #(
  parameter int UV_DELAY_TICKS = hbd_pkg::UV_DELAY_US
) (
  input wire logic                    REF_CLK_I,
  input wire logic                    SYS_RST_I,
  input wire logic                    CS_N_I,
  input wire logic                    SDO_OE_O,
  input wire logic                    ENABLE_I,
  input wire logic                    VCC_OK_I,
  input wire logic [hbd_pkg::NCH-1:0] TEMP_SD_I,
  input wire logic                    VS_UV_I,
  input wire logic [hbd_pkg::NCH-1:0] HS_ON_O,
  input wire logic [hbd_pkg::NCH-1:0] LS_ON_O
);
  import hbd_pkg::*;
  // Slack covers the tick phase and the synchroniser.
  localparam int UV_LIM = (UV_DELAY_TICKS + 2) * TICK_CYCLES + 4;
  int uv_cnt;
  int aw_cnt;
  logic [NCH-1:0] t1, t2, t3, t4;
  wire logic [NCH-1:0] hot = TEMP_SD_I & t1 & t2 & t3 & t4;
  wire logic [NCH-1:0] on = HS_ON_O | LS_ON_O;
  // Counts supply-low and awake time; delays the thermal levels.
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      {uv_cnt, aw_cnt} <= '0;
      {t1, t2, t3, t4} <= '0;
    end else begin
      uv_cnt <= VS_UV_I ? uv_cnt + 1 : 0;
      aw_cnt <= (ENABLE_I && VCC_OK_I) ? ((aw_cnt < 15) ? aw_cnt + 1 : 15) : 0;
      {t1, t2, t3, t4} <= {TEMP_SD_I, t1, t2, t3};
    end
  end
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  AST_NO_SHOOT: assert property (!(|(HS_ON_O & LS_ON_O)))
    else $error("both switches on");
  AST_SLEEP_OFF: assert property (!ENABLE_I [*4] |-> on == '0)
    else $error("drive while asleep");
  AST_VCC_OFF: assert property (!VCC_OK_I [*4] |-> on == '0)
    else $error("drive with logic supply low");
  AST_SLEEP_SDO: assert property (!ENABLE_I [*4] |-> !SDO_OE_O)
    else $error("data out driven asleep");
  AST_TSD_OFF: assert property ((hot & on) == '0)
    else $error("hot channel still driven");
  AST_UV_OFF: assert property (uv_cnt > UV_LIM |-> on == '0)
    else $error("drive during supply fail");
  AST_OE_ON: assert property ($fell(CS_N_I) && aw_cnt > 8 |-> ##[3:4] SDO_OE_O)
    else $error("data out not enabled");
  AST_OE_OFF: assert property ($rose(CS_N_I) |-> ##[1:5] !SDO_OE_O)
    else $error("data out held after frame");
  cover property (uv_cnt > UV_LIM);
  cover property (|hot);
  cover property ($fell(CS_N_I) && aw_cnt > 8);
endmodule
bind hbd_fault_diag hbd_fault_diag_chk #(.UV_DELAY_TICKS(UV_DELAY_TICKS)) hbd_fault_diag_chk_inst (
  .REF_CLK_I, .SYS_RST_I, .CS_N_I, .SDO_OE_O, .ENABLE_I, .VCC_OK_I, .TEMP_SD_I, .VS_UV_I, .HS_ON_O, .LS_ON_O);
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
//==========
// Bench: host frames plus comparator levels, checked at the pins.
module tb_top;
  import hbd_pkg::*;
  // Group two, all enabled, ch7 and ch9 on high side, lockout armed.
  localparam logic [15:0] G2 = 16'h478b;
  logic clk = 1'h0, rst = 1'h1, en = 1'h1, vok = 1'h1, uv = 1'h0, ov = 1'h0;
  logic sclk, cs_n, di, sdo, sdo_oe;
  logic [NCH-1:0] ul = '0, oc = '0, tw = '0, thermal_shutdown_flag = '0, hs, ls;
  int miscompares = 0, n_compared = 0, cyc = 0;
  always #4 clk = ~clk;
  // Small delays keep the run short; expectations follow from them.
  hbd_fault_diag #(.OL_DELAY_TICKS(2), .OC_DELAY_TICKS(2), .UV_DELAY_TICKS(2)) hbd_fault_diag_inst (
    .REF_CLK_I(clk), .SYS_RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n), .SERIAL_DATA_IN_I(di), .SDO_O(sdo),
    .SDO_OE_O(sdo_oe), .ENABLE_I(en), .VCC_OK_I(vok), .UNDERLOAD_I(ul), .OVERCUR_I(oc), .TEMP_WARN_I(tw),
    .TEMP_SD_I(thermal_shutdown_flag), .VS_UV_I(uv), .VS_OV_I(ov), .HS_ON_O(hs), .LS_ON_O(ls));
  hbd_host hbd_host_inst (.clk_i(clk), .sdo_i(sdo), .sclk_o(sclk), .cs_n_o(cs_n), .di_o(di));
  task automatic cmp_out(input logic [NCH-1:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t drive %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_word(input logic [16:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t word %h exp %h", $time, got, exp);
    end
  endtask
  // One frame: the word read is the state before it, drive the state after.
  task automatic step(input logic [15:0] cmd, input logic [16:0] wd, input logic [NCH-1:0] h, l);
    logic [16:0] rd;
    hbd_host_inst.xfer(cmd, rd);
    cmp_word(rd, wd);
    cmp_out(hs, h);
    cmp_out(ls, l);
  endtask
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // A hang counts as a mismatch and closes the run.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    hbd_host_inst.w(5);
    rst = 1'h0;
    hbd_host_inst.w(5);
    step(G2, 17'h0, 10'h140, 10'h280);
    tw[6] = 1'h1;
    thermal_shutdown_flag[6] = 1'h1;
    hbd_host_inst.w(10);
    step(G2, 17'h1070b, 10'h100, 10'h280);
    step(16'hc78b, 17'h1070b, 10'h100, 10'h280);
    {tw[6], thermal_shutdown_flag[6]} = 2'h0;
    hbd_host_inst.w(10);
    step(16'h8000, 17'h1070a, 10'h100, 10'h280);
    step(16'hc78b, 17'h0, 10'h140, 10'h280);
    $display("thermal test done");
    oc[7] = 1'h1;
    hbd_host_inst.w(600);
    step(G2, 17'h0868a, 10'h140, 10'h200);
    oc[7] = 1'h0;
    step(16'hc78b, 17'h0868a, 10'h140, 10'h280);
    $display("overcurrent test done");
    step(16'h678b, 17'h0078a, 10'h140, 10'h280);
    ul[7] = 1'h1;
    hbd_host_inst.w(60);
    ul[9] = 1'h1;
    for (int k = 0; k < 500 && ls[7] === 1'h1; k++) hbd_host_inst.w(1);
    hbd_host_inst.w(2);
    cmp_out(ls, 10'h000);
    step(16'h678b, 17'h0228a, 10'h140, 10'h000);
    ul = '0;
    step(16'hc78b, 17'h0228a, 10'h140, 10'h280);
    ul[7] = 1'h1;
    hbd_host_inst.w(600);
    step(G2, 17'h0278a, 10'h140, 10'h280);
    ul = '0;
    step(16'hc78b, 17'h0278a, 10'h140, 10'h280);
    $display("open-load test done");
    uv = 1'h1;
    hbd_host_inst.w(800);
    step(G2, 17'h0400a, 10'h000, 10'h000);
    uv = 1'h0;
    hbd_host_inst.w(10);
    cmp_out(hs, 10'h140);
    ov = 1'h1;
    hbd_host_inst.w(10);
    cmp_out(ls, 10'h000);
    step(16'h478a, 17'h0400a, 10'h140, 10'h280);
    ov = 1'h0;
    $display("supply test done");
    thermal_shutdown_flag[9] = 1'h1;
    hbd_host_inst.w(10);
    thermal_shutdown_flag[9] = 1'h0;
    en = 1'h0;
    // Every channel comparator fires while asleep; none may drive or latch.
    {ul, oc, tw, thermal_shutdown_flag} = {(4 * NCH){1'h1}};
    hbd_host_inst.w(6);
    cmp_out(hs | ls, 10'h000);
    {ul, oc, tw, thermal_shutdown_flag} = {(4 * NCH){1'h0}};
    en = 1'h1;
    hbd_host_inst.w(6);
    step(G2, 17'h0, 10'h140, 10'h280);
    vok = 1'h0;
    hbd_host_inst.w(6);
    cmp_out(hs | ls, 10'h000);
    vok = 1'h1;
    hbd_host_inst.w(6);
    step(G2, 17'h0, 10'h140, 10'h280);
    // Brake on the high sides only, so no false under-load is seen.
    step(16'h479f, 17'h0078a, 10'h3c0, 10'h000);
    $display("sleep test done");
    test_done();
  end
endmodule
`default_nettype wire
